// File: dv/lsg_pin_model.sv
// Far side of the port pins: a device driving input pins.
// Assumes no pull resistors, so undriven pins follow a counter that steps every cycle.
`timescale 1ns/1ps
module lsg_pin_model (
   input  wire logic       clock,
   input  wire logic [7:0] pinOut,
   input  wire logic [7:0] pinOe,
   input  wire logic [7:0] drvVal,
   input  wire logic [7:0] drvEn,
   output wire logic [7:0] pinLevel
);
   logic [7:0] churn = 8'h00;
   // Floating pins follow a counter stepped by 8'h5b each cycle so a stray read never matches.
   always @(posedge clock) churn <= churn + 8'h5b;
   assign pinLevel = (pinOe & pinOut) | (~pinOe & drvEn & drvVal)
                   | (~pinOe & ~drvEn & churn);
endmodule // lsg_pin_model

// File: dv/lsg_ports_sva.sv
// Checker for lsg_ports: pin functions, power states, direction reads.
// Assumes pin outputs follow their controls one edge later.
`timescale 1ns/1ps
`include "lsg_port_defs.vh"
module lsg_ports_sva #(
   parameter WIDTH = 8
) (
   input wire logic             clock,
   input wire logic             reset,
   input wire logic [15:0]      address,
   input wire logic             readStrobe,
   input wire logic [7:0]       readData,
   input wire logic [2:0]       powerMode,
   input wire logic [15:0]      segmentLevel,
   input wire logic             latchClockOut,
   input wire logic             shiftClockOut,
   input wire logic             serialDataOut,
   input wire logic             acDriveOut,
   input wire logic [WIDTH-1:0] portA7Out,
   input wire logic [WIDTH-1:0] portA7Oe,
   input wire logic [WIDTH-1:0] portB8Out,
   input wire logic [WIDTH-1:0] portB8Oe,
   input wire logic [3:0]       segmentSelectField,
   input wire logic             expansionSelectBit
);
   wire [3:0] f = segmentSelectField;
   wire [3:0] lv = {latchClockOut, shiftClockOut, serialDataOut, acDriveOut};
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_run;
      powerMode == `LSG_PM_ACTIVE;
   endsequence
   sequence s_dir_rd;
      readStrobe && (address == `LSG_ADDR_A7_DIR ||
                     address == `LSG_ADDR_B8_DIR);
   endsequence
   a_a7_segment: assert property (
      s_run ##0 (f[3:2] != 2'h0) |=> portA7Oe == 8'hff &&
      portA7Out == $past(segmentLevel[7:0])) else $error("a7 segment");
   a_b8_low_seg: assert property (
      s_run ##0 (f[3:1] != 3'h0) |=> portB8Oe[3:0] == 4'hf &&
      portB8Out[3:0] == $past(segmentLevel[11:8])) else $error("b8 low");
   a_b8_up_seg: assert property (
      s_run ##0 (f[3:1] != 3'h0) |=> portB8Oe[7:4] == 4'hf &&
      portB8Out[7:4] == $past(segmentLevel[15:12])) else $error("b8 up");
   a_exp_drive: assert property (
      s_run ##0 (f == 4'h0 && expansionSelectBit) |=> portB8Oe[7:4] == 4'hf
      && portB8Out[7:4] == $past(lv)) else $error("expansion drive");
   a_reset_float: assert property (
      $fell(reset) |-> portA7Oe == 8'h00 && portB8Oe == 8'h00)
      else $error("driven after reset");
   a_standby_off: assert property (
      powerMode == `LSG_PM_STANDBY |=> portA7Oe == 8'h00 &&
      portB8Oe == 8'h00) else $error("driven in standby");
   a_b8_hold: assert property (
      powerMode inside {`LSG_PM_SLEEP, `LSG_PM_SUBSLEEP, `LSG_PM_WATCH}
      |=> $stable(portB8Out) && $stable(portB8Oe)) else $error("b8 hold");
   a_a7_hold: assert property (
      powerMode == `LSG_PM_SUBSLEEP |=> $stable(portA7Out) &&
      $stable(portA7Oe)) else $error("a7 hold");
   a_dir_ones: assert property (
      s_dir_rd |=> readData == 8'hff) else $error("direction read");
endmodule // lsg_ports_sva
bind lsg_ports lsg_ports_sva #(.WIDTH(WIDTH)) i_sva (.clock, .reset,
   .address, .readStrobe, .readData, .powerMode, .segmentLevel,
   .latchClockOut, .shiftClockOut, .serialDataOut, .acDriveOut,
   .portA7Out, .portA7Oe, .portB8Out, .portB8Oe, .segmentSelectField,
   .expansionSelectBit);

// File: dv/tb_top.sv
// Self-checking bench for lsg_ports with a pin model on each port.
// Assumes reads answer in the cycle after the strobe.
`timescale 1ns/1ps
`include "lsg_port_defs.vh"
module tb_top;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] address = 16'h0000;
   logic [7:0]  writeData = 8'h00;
   logic        writeStrobe = 1'b0;
   logic        readStrobe = 1'b0;
   logic [2:0]  powerMode = `LSG_PM_ACTIVE;
   logic [15:0] segmentLevel = 16'h0000;
   logic [3:0]  expLv = 4'h0;
   logic [7:0]  drvVal = 8'h00;
   logic [7:0]  drvEn = 8'hff;
   wire  [7:0]  readData, a7In, a7Out, a7Oe, b8In, b8Out, b8Oe;
   wire  [3:0]  segSel;
   wire         expSel;
   logic [31:0] seed = 32'hc8f80fb8;
   logic [31:0] e;
   logic [15:0] snap;
   logic [7:0]  d, l, p, r;
   int          errorCnt = 0;
   int          numChecks = 0;
   int          cycles = 0;
   lsg_ports i_dut (.clock(clock), .reset(reset), .address(address),
      .writeData(writeData), .writeStrobe(writeStrobe),
      .readStrobe(readStrobe), .readData(readData), .powerMode(powerMode),
      .segmentLevel(segmentLevel), .latchClockOut(expLv[3]),
      .shiftClockOut(expLv[2]), .serialDataOut(expLv[1]),
      .acDriveOut(expLv[0]), .portA7In(a7In), .portA7Out(a7Out),
      .portA7Oe(a7Oe), .portB8In(b8In), .portB8Out(b8Out), .portB8Oe(b8Oe),
      .segmentSelectField(segSel), .expansionSelectBit(expSel));
   lsg_pin_model i_a7 (.clock(clock), .pinOut(a7Out), .pinOe(a7Oe),
      .drvVal(drvVal), .drvEn(drvEn), .pinLevel(a7In));
   lsg_pin_model i_b8 (.clock(clock), .pinOut(b8Out), .pinOe(b8Oe),
      .drvVal(drvVal), .drvEn(drvEn), .pinLevel(b8In));
   initial begin
      forever #4 clock = ~clock;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] pins(input logic [4:0] c,
                                        input logic [7:0] dir, lat);
      logic [7:0] ao, ae, bo, be;
      ae = (c[3:2] == 2'h0) ? dir : 8'hff;
      ao = (c[3:2] == 2'h0) ? lat & dir : segmentLevel[7:0];
      be = (c[3:1] == 3'h0) ? dir : 8'hff;
      bo = (c[3:1] == 3'h0) ? lat & dir : segmentLevel[15:8];
      if (c == 5'h10) begin
         be[7:4] = 4'hf;
         bo[7:4] = expLv;
      end
      return {ae, ao, be, bo};
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, exp);
      numChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clock);
      address     <= a;
      writeData   <= v;
      writeStrobe <= 1'b1;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge clock);
      address    <= a;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 v = readData;
   endtask
   task automatic closeOut();
      if (errorCnt == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errorCnt++;
         closeOut();
      end
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      #1 chk("b8 oe", b8Oe, 8'h00);
      rd(`LSG_ADDR_B8_DIR, r);
      chk("b8 dir", r, `LSG_DIR_READ);
      @(posedge clock);
      #1 chk("rd idle", readData, 8'h00);
      rd(`LSG_ADDR_A7_DIR, r);
      chk("a7 dir", r, `LSG_DIR_READ);
      rd(16'h1234, r);
      chk("unmapped", r, `LSG_UNMAPPED_READ);
      wr(`LSG_ADDR_B8_DIR, 8'hff);
      rd(`LSG_ADDR_B8_LATCH, r);
      chk("b8 latch", r, `LSG_LATCH_RESET);
      repeat (24) begin
         {d, l, p, r} = xs();
         @(posedge clock);
         drvVal <= p;
         wr(`LSG_ADDR_B8_LATCH, l);
         wr(`LSG_ADDR_B8_DIR, d);
         wr(`LSG_ADDR_A7_LATCH, ~l);
         wr(`LSG_ADDR_A7_DIR, d);
         @(posedge clock);
         #1 chk("b8 pins", {b8Oe, b8Out}, {d, l & d});
         rd(`LSG_ADDR_B8_LATCH, r);
         chk("b8 read", r, (l & d) | (p & ~d));
         rd(`LSG_ADDR_A7_LATCH, r);
         chk("a7 read", r, (~l & d) | (p & ~d));
      end
      wr(`LSG_ADDR_A7_LATCH, l);
      for (int i = 0; i < 32; i++) begin
         {snap, p, r} = xs();
         @(posedge clock);
         segmentLevel <= snap;
         expLv        <= p[3:0];
         wr(`LSG_ADDR_LCD_CTRL, {3'h0, i[4:0]});
         @(posedge clock);
         #1 e = pins(i[4:0], d, l);
         chk("port a7", {a7Oe, a7Out}, e[31:16]);
         chk("port b8", {b8Oe, b8Out}, e[15:0]);
         chk("ctrl", {expSel, segSel}, i[4:0]);
         rd(`LSG_ADDR_PIN_STATUS, r);
         chk("status", r, {5'h00, i[4:0] == 5'h10, i[3:1] == 3'h0,
             i[3:2] == 2'h0});
      end
      // Sleep, subsleep and watch are the codes 2 to 4.
      for (int k = 2; k < 5; k++) begin
         @(posedge clock);
         powerMode <= k[2:0];
         repeat (2) @(posedge clock);
         #1 snap = {b8Oe, b8Out};
         @(posedge clock);
         segmentLevel <= ~segmentLevel;
         repeat (3) @(posedge clock);
         #1 chk("b8 hold", {b8Oe, b8Out}, snap);
         rd(`LSG_ADDR_POWER_MODE, r);
         chk("power mode", r, {5'h00, k[2:0]});
      end
      @(posedge clock);
      powerMode <= `LSG_PM_STANDBY;
      repeat (2) @(posedge clock);
      #1 chk("float", {a7Oe, b8Oe, a7Out, b8Out}, 32'h0);
      @(posedge clock);
      powerMode <= `LSG_PM_SUBACTIVE;
      repeat (2) @(posedge clock);
      #1 e = pins(5'h1f, d, l);
      chk("subactive a7", {a7Oe, a7Out}, e[31:16]);
      chk("subactive b8", {b8Oe, b8Out}, e[15:0]);
      closeOut();
   end
endmodule // tb_top

// File: rtl/lsg_pin_cell.v
// One port pin cell: function select, hold and read-back for one pin.
// Assumes the pin input is already synchronised to clock.
`timescale 1ns/1ps
module lsg_pin_cell (
   input  wire clock,
   input  wire reset,
   input  wire isGpio,
   input  wire altDrive,
   input  wire altLevel,
   input  wire dirBit,
   input  wire latchBit,
   input  wire pinSync,
   input  wire hold,
   input  wire float,
   output reg  pinOut,
   output reg  pinOe,
   output wire readBit
);
   reg next_pinOut;
   reg next_pinOe;

   // Function choice is combinational from the live control bits.
   always @* begin
      if (isGpio) begin
         next_pinOe  = dirBit;
         next_pinOut = dirBit & latchBit;
      end else begin
         next_pinOe  = altDrive;
         next_pinOut = altLevel;
      end
   end

   // Hold freezes the pin registers so the pad keeps its last state.
   always @(posedge clock) begin
      if (reset) begin
         pinOut <= 1'h0;
         pinOe  <= 1'h0;
      end else if (float) begin
         pinOut <= 1'h0;
         pinOe  <= 1'h0;
      end else if (!hold) begin
         pinOut <= next_pinOut;
         pinOe  <= next_pinOe;
      end
   end

   assign readBit = dirBit ? latchBit : pinSync;
endmodule // lsg_pin_cell

// File: rtl/lsg_port_defs.vh
// Constants for the LCD-shared general-purpose ports 7 and 8.
// Assumes a byte-wide register port with byte addresses as printed.
`ifndef LSG_PORT_DEFS_VH
`define LSG_PORT_DEFS_VH

`define LSG_ADDR_W          16
`define LSG_ADDR_A7_LATCH   16'hffda
`define LSG_ADDR_B8_LATCH   16'hffdb
`define LSG_ADDR_A7_DIR     16'hffea
`define LSG_ADDR_B8_DIR     16'hffeb
`define LSG_ADDR_LCD_CTRL   16'hfff0
`define LSG_ADDR_PIN_STATUS 16'hfff1
`define LSG_ADDR_POWER_MODE 16'hfff2

`define LSG_LATCH_RESET     8'h00
`define LSG_DIR_RESET       8'h00
`define LSG_DIR_READ        8'hff
`define LSG_CTRL_RESET      8'h00
`define LSG_UNMAPPED_READ   8'h00

// Control register fields: segment select in [3:0], expansion in [4].
`define LSG_SEG_SEL_HI      3
`define LSG_SEG_SEL_LO      0
`define LSG_EXP_BIT         4

// Power-mode encoding written by the system power controller.
`define LSG_PM_W            3
`define LSG_PM_ACTIVE       3'h0
`define LSG_PM_SUBACTIVE    3'h1
`define LSG_PM_SLEEP        3'h2
`define LSG_PM_SUBSLEEP     3'h3
`define LSG_PM_WATCH        3'h4
`define LSG_PM_STANDBY      3'h5

// First segment numbers carried by each pin group.
`define LSG_A7_SEG_BASE     17
`define LSG_B8_LOW_SEG_BASE 25

`endif

// File: rtl/lsg_ports.v
// Ports 7 and 8 with LCD segment and expansion-driver sharing.
// Assumes a single-cycle register port on clock; pins are asynchronous
// and pass two flip-flops; segment and expansion levels come from the
// LCD controller on the same clock; powerMode from the power controller.
//
// Notes on behaviour
// - Port 7: field 00xx GPIO, else segment n+17.
// - Port 7 floats in reset/standby, holds subsleep.
// - Port 8 latch holds eight output bits.
// - Port 8 read: latch if output, else pin.
// - Port 8 latch resets to zero.
// - Port 8 direction one drives, zero inputs.
// - Direction and latch act only in GPIO.
// - Port 8 direction write-only, reads all ones.
// - Port 8 direction resets to zero.
// - Field 0000 with expansion: pins 7-4 expansion signals.
// - Port 8 upper: 000x GPIO, else segments 32-29.
// - Port 8 lower: 000x GPIO, else segment n+25.
// - Port 8 floats reset/standby, holds sleep/subsleep/watch.
// - Port 7 read mixes latch and pin; zero reset.
// - Port 7 direction write-only, all ones, resets zero.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "lsg_port_defs.vh"
module lsg_ports #(
   parameter WIDTH = 8
) (
   input  wire                   clock,
   input  wire                   reset,
   input  wire [`LSG_ADDR_W-1:0] address,
   input  wire [7:0]             writeData,
   input  wire                   writeStrobe,
   input  wire                   readStrobe,
   output reg  [7:0]             readData,
   input  wire [`LSG_PM_W-1:0]   powerMode,
   input  wire [15:0]            segmentLevel,
   input  wire                   latchClockOut,
   input  wire                   shiftClockOut,
   input  wire                   serialDataOut,
   input  wire                   acDriveOut,
   input  wire [WIDTH-1:0]       portA7In,
   output wire [WIDTH-1:0]       portA7Out,
   output wire [WIDTH-1:0]       portA7Oe,
   input  wire [WIDTH-1:0]       portB8In,
   output wire [WIDTH-1:0]       portB8Out,
   output wire [WIDTH-1:0]       portB8Oe,
   output wire [3:0]             segmentSelectField,
   output wire                   expansionSelectBit
);
   reg  [WIDTH-1:0] portA7OutputLatch;
   reg  [WIDTH-1:0] portA7Direction;
   reg  [WIDTH-1:0] portB8OutputLatch;
   reg  [WIDTH-1:0] portB8Direction;
   reg  [7:0]       lcdPortControlReg;
   reg  [WIDTH-1:0] a7Meta;
   reg  [WIDTH-1:0] a7Sync;
   reg  [WIDTH-1:0] b8Meta;
   reg  [WIDTH-1:0] b8Sync;
   wire [WIDTH-1:0] a7Read;
   wire [WIDTH-1:0] b8Read;
   reg  [7:0]       next_readData;

   assign segmentSelectField =
      lcdPortControlReg[`LSG_SEG_SEL_HI:`LSG_SEG_SEL_LO];
   assign expansionSelectBit = lcdPortControlReg[`LSG_EXP_BIT];

   // Function decode of the segment select field.
   wire a7Gpio  = (segmentSelectField[3:2] == 2'h0);
   wire b8Gpio  = (segmentSelectField[3:1] == 3'h0);
   wire expMode = (segmentSelectField == 4'h0) &
                  expansionSelectBit;
   // With the field at 0001 the expansion bit does not apply, so the
   // upper pins stay GPIO; only 0000 with the bit set selects it.
   wire b8HiGpio = b8Gpio & ~expMode;

   // Power-mode handling per port; active and subactive run normally.
   wire isStandby = (powerMode == `LSG_PM_STANDBY);
   wire a7Hold    = (powerMode == `LSG_PM_SUBSLEEP);
   wire b8Hold    = (powerMode == `LSG_PM_SLEEP) |
                    (powerMode == `LSG_PM_SUBSLEEP) |
                    (powerMode == `LSG_PM_WATCH);

   // Pins are asynchronous; only the second stage is read by logic.
   always @(posedge clock) begin
      if (reset) begin
         a7Meta <= {WIDTH{1'h0}};
         a7Sync <= {WIDTH{1'h0}};
         b8Meta <= {WIDTH{1'h0}};
         b8Sync <= {WIDTH{1'h0}};
      end else begin
         a7Meta <= portA7In;
         a7Sync <= a7Meta;
         b8Meta <= portB8In;
         b8Sync <= b8Meta;
      end
   end

   // Register writes.
   always @(posedge clock) begin
      if (reset) begin
         portA7OutputLatch <= `LSG_LATCH_RESET;
         portA7Direction   <= `LSG_DIR_RESET;
         portB8OutputLatch <= `LSG_LATCH_RESET;
         portB8Direction   <= `LSG_DIR_RESET;
         lcdPortControlReg <= `LSG_CTRL_RESET;
      end else if (writeStrobe) begin
         case (address)
            `LSG_ADDR_A7_LATCH: portA7OutputLatch <= writeData;
            `LSG_ADDR_A7_DIR:   portA7Direction   <= writeData;
            `LSG_ADDR_B8_LATCH: portB8OutputLatch <= writeData;
            `LSG_ADDR_B8_DIR:   portB8Direction   <= writeData;
            `LSG_ADDR_LCD_CTRL: lcdPortControlReg <= writeData;
            default: ;
         endcase
      end
   end

   // Read mux; data stand for exactly the cycle after the strobe.
   always @* begin
      case (address)
         `LSG_ADDR_A7_LATCH:   next_readData = a7Read;
         `LSG_ADDR_A7_DIR:     next_readData = `LSG_DIR_READ;
         `LSG_ADDR_B8_LATCH:   next_readData = b8Read;
         `LSG_ADDR_B8_DIR:     next_readData = `LSG_DIR_READ;
         `LSG_ADDR_LCD_CTRL:   next_readData = lcdPortControlReg;
         `LSG_ADDR_PIN_STATUS: next_readData =
            {5'h00, expMode, b8Gpio, a7Gpio};
         `LSG_ADDR_POWER_MODE: next_readData = {5'h00, powerMode};
         default:              next_readData = `LSG_UNMAPPED_READ;
      endcase
   end

   always @(posedge clock) begin
      if (reset)
         readData <= 8'h00;
      else if (readStrobe)
         readData <= next_readData;
      else
         readData <= 8'h00;
   end

   // Expansion signals on pins 7 to 4 in that order.
   wire [3:0] expLevel = {latchClockOut, shiftClockOut,
                          serialDataOut, acDriveOut};

   genvar n;
   generate
      for (n = 0; n < WIDTH; n = n + 1) begin : g_pin
         // Port 7 pin n carries segment n+17; bit 0 of the bus is 17.
         lsg_pin_cell u_a7 (
            .clock    (clock),
            .reset    (reset),
            .isGpio   (a7Gpio),
            .altDrive (1'h1),
            .altLevel (segmentLevel[n]),
            .dirBit   (portA7Direction[n]),
            .latchBit (portA7OutputLatch[n]),
            .pinSync  (a7Sync[n]),
            .hold     (a7Hold),
            .float    (isStandby),
            .pinOut   (portA7Out[n]),
            .pinOe    (portA7Oe[n]),
            .readBit  (a7Read[n])
         );
         // Port 8 pin n carries segment n+25, bus bit n+8.
         if (n >= 4) begin : g_hi
            lsg_pin_cell u_b8 (
               .clock    (clock),
               .reset    (reset),
               .isGpio   (b8HiGpio),
               .altDrive (1'h1),
               .altLevel (expMode ? expLevel[n-4]
                                  : segmentLevel[n+8]),
               .dirBit   (portB8Direction[n]),
               .latchBit (portB8OutputLatch[n]),
               .pinSync  (b8Sync[n]),
               .hold     (b8Hold),
               .float    (isStandby),
               .pinOut   (portB8Out[n]),
               .pinOe    (portB8Oe[n]),
               .readBit  (b8Read[n])
            );
         end else begin : g_lo
            lsg_pin_cell u_b8 (
               .clock    (clock),
               .reset    (reset),
               .isGpio   (b8Gpio),
               .altDrive (1'h1),
               .altLevel (segmentLevel[n+8]),
               .dirBit   (portB8Direction[n]),
               .latchBit (portB8OutputLatch[n]),
               .pinSync  (b8Sync[n]),
               .hold     (b8Hold),
               .float    (isStandby),
               .pinOut   (portB8Out[n]),
               .pinOe    (portB8Oe[n]),
               .readBit  (b8Read[n])
            );
         end
      end
   endgenerate
endmodule // lsg_ports
